// [rtl/bldc_hall_consts.vh]
// register map, field layout, reset values and number formats of the hall drive
`ifndef BLDC_HALL_CONSTS_VH
`define BLDC_HALL_CONSTS_VH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define OFS_CTRL        8'h00
`define OFS_SCALE       8'h04
`define OFS_KP          8'h08
`define OFS_KI          8'h0c
`define OFS_SPEED_REQ   8'h10
`define OFS_TB_DIV      8'h14
`define OFS_CMD_INDEX   8'h18
`define OFS_CMD_DATA    8'h1c
`define OFS_REV_PERIOD  8'h20
`define OFS_SECT_PERIOD 8'h24
`define OFS_OMEGA       8'h28
`define OFS_VOLTAGE     8'h2c
`define OFS_STATUS      8'h30
// ****************************************************************
// control bits and reset values
// ****************************************************************
`define CTRL_ENABLE     0
`define CTRL_SECTOR     1
`define CTRL_DIR_INC    2
`define CTRL_RST        3'h0
`define TB_DIV_RST      16'h0000
// ****************************************************************
// 1.23 fraction limits and gain format
// ****************************************************************
`define FRAC_MAX        24'h7fffff
`define FRAC_MIN        24'h800000
`define SHIFT_1_23      6'h17
`define SHIFT_9_15      6'h0f
`define SECTORS_PER_REV 3'h6
// ****************************************************************
// commutation command fields and channel states
// ****************************************************************
`define CMD_CH_LSB      0
`define CMD_BASE_LSB    8
`define CMD_COMP_LSB    16
`define CMD_OPT_LSB     24
`define ST_ON_HIGH      2'h0
`define ST_ON_LOW       2'h1
`define ST_OFF_LOW      2'h2
`define ST_OFF_HIGH     2'h3
`define OPT_DUTY_INVERT_SIGN    0
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// [rtl/bldc_hall_drive.v]
// hall sensor decoder, speed loop regulator and commutation for a brushless dc drive
// Overview of operation
// - real quantities are signed 1.23 fractions
// - minus one 0x800000, maximum 0x7fffff
// - gains arrive as 32-bit signed 9.23
// - gains reduced to 9.15 or 1.23 by magnitude
// - speed from revolution period, optionally sector period
// - sector period between consecutive hall edges
// - revolution period same edge, refreshed every edge
// - speed equals scale constant over period
// - each hall edge applies off then on
// - command word holds four byte fields
// - four states per base and complementary channel
// - negative option negates the signed duty
// - option immediate on switch-on, held on switch-off
// - regulation runs every second pwm period
// - hall edges serviced without waiting for pwm
// - controller output becomes applied motor voltage
`include "bldc_hall_consts.vh"
module bldc_hall_drive
(
  // clock and reset
  input  wire         aclk,
  input  wire         aresetn,
  // axi4-lite write address and data
  input  wire [7:0]   s_axi_awaddr,
  input  wire         s_axi_awvalid,
  output reg          s_axi_awready,
  input  wire [31:0]  s_axi_wdata,
  input  wire [3:0]   s_axi_wstrb,
  input  wire         s_axi_wvalid,
  output reg          s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]   s_axi_bresp,
  output reg          s_axi_bvalid,
  input  wire         s_axi_bready,
  // axi4-lite read
  input  wire [7:0]   s_axi_araddr,
  input  wire         s_axi_arvalid,
  output reg          s_axi_arready,
  output reg  [31:0]  s_axi_rdata,
  output reg  [1:0]   s_axi_rresp,
  output reg          s_axi_rvalid,
  input  wire         s_axi_rready,
  // hall sensor pins and pwm period tick
  input  wire [2:0]   hall_in,
  input  wire         pwm_period_tick,
  // pwm phase commands
  output reg  [5:0]   phase_base_state_r,
  output reg  [5:0]   phase_comp_state_r,
  output reg  [2:0]   duty_invert_sign_r,
  output reg  [71:0]  phase_duty_r,
  output reg  [23:0]  voltage_r,
  output reg          voltage_valid_r
);
  // ****************************************************************
  // helpers
  // ****************************************************************
  // clamp a wide signed value into the 1.23 range
  function [23:0] sat24;
    input signed [49:0] v;
    begin
      if (v > $signed(50'h00000007fffff))
        sat24 = `FRAC_MAX;
      else if (v < $signed(50'h3ffffff800000))
        sat24 = `FRAC_MIN;
      else
        sat24 = v[23:0];
    end
  endfunction
  // reduce a 9.23 gain: {1=9.15 form, 24-bit value}
  function [24:0] gain_fmt;
    input [31:0] g;
    begin
      if ((g[31:23] == 9'h000) || (g[31:23] == 9'h1ff))
        gain_fmt = {1'b0, g[23:0]};
      else
        gain_fmt = {1'b1, g[31:8]};
    end
  endfunction
  // ****************************************************************
  // registers and state
  // ****************************************************************
  reg  [2:0]   ctrl_r;             // enable, sector mode, direction
  reg  [23:0]  scale_r;            // speed scale constant
  reg  [31:0]  kp_r;               // proportional gain 9.23
  reg  [31:0]  ki_r;               // integral gain 9.23
  reg  [23:0]  speed_req_r;        // required speed fraction
  reg  [15:0]  tb_div_r;           // timebase prescaler
  reg  [4:0]   cmd_index_r;        // table pointer for software
  reg  [31:0]  cmd_tab_r [0:31];   // commutation commands
  reg  [2:0]   hall_s1_r;          // synchroniser first stage
  reg  [2:0]   hall_s2_r;          // synchroniser second stage
  reg  [2:0]   hall_q_r;           // last serviced hall level
  reg  [15:0]  tb_pre_r;           // prescaler count
  reg  [23:0]  timebase_counter;   // free running tick count
  reg  [23:0]  stamp_r [0:5];      // last time of each edge kind
  reg  [23:0]  last_edge_r;        // time of any last edge
  reg  [23:0]  rev_period_r;       // revolution period in ticks
  reg  [23:0]  sect_period_r;      // sector period in ticks
  reg  [2:0]   neg_pend_r;         // options held for off phases
  reg  [4:0]   cmd_ptr_r;          // command being applied
  reg  [2:0]   cm_state_r;         // commutation fsm, one-hot
  reg  [2:0]   rg_state_r;         // regulation fsm, one-hot
  reg          pwm_par_r;          // pwm period parity
  reg  [24:0]  rem_r;              // divider remainder
  reg  [23:0]  dvd_r;              // divider dividend shifter
  reg  [23:0]  dvs_r;              // divider divisor
  reg  [23:0]  quo_r;              // divider quotient
  reg  [4:0]   div_cnt_r;          // divider step count
  reg  [23:0]  omega_r;            // measured speed fraction
  reg  [23:0]  integ_r;            // integral accumulator
  reg          aw_held_r;          // write address taken
  reg          w_held_r;           // write data taken
  reg  [7:0]   awaddr_r;           // held write address
  reg  [31:0]  wdata_r;            // held write data
  reg  [3:0]   wstrb_r;            // held byte enables
  localparam [2:0] CM_IDLE = 3'h1, CM_OFF = 3'h2, CM_ON = 3'h4;
  localparam [2:0] RG_IDLE = 3'h1, RG_DIV = 3'h2, RG_PI = 3'h4;
  integer k;
  integer j;                       // stamp reset index
  // ****************************************************************
  // hall edge selection
  // ****************************************************************
  wire [2:0]  hall_edge = hall_s2_r ^ hall_q_r;
  wire [1:0]  edge_ch = hall_edge[0] ? 2'h0 : (hall_edge[1] ? 2'h1 : 2'h2);
  wire        edge_rise = hall_s2_r[edge_ch];
  wire [2:0]  edge_kind = {edge_ch, edge_rise};
  // incremental pairs at 0..15, decremental at 16..31
  wire [4:0]  edge_cmd = {~ctrl_r[`CTRL_DIR_INC], edge_ch, edge_rise, 1'b0};
  wire        edge_take = (|hall_edge) && ctrl_r[`CTRL_ENABLE] && cm_state_r[0];
  wire [31:0] cmd_cur = cmd_tab_r[cmd_ptr_r];
  wire [1:0]  cmd_ph = cmd_cur[`CMD_CH_LSB +: 2];
  wire [1:0]  cmd_base = cmd_cur[`CMD_BASE_LSB +: 2];
  wire [1:0]  cmd_comp = cmd_cur[`CMD_COMP_LSB +: 2];
  wire        cmd_neg = cmd_cur[`CMD_OPT_LSB + `OPT_DUTY_INVERT_SIGN];
  wire        cmd_is_on = ~cmd_base[1];
  // ****************************************************************
  // period selection and controller arithmetic
  // ****************************************************************
  wire [26:0] sect6 = sect_period_r * `SECTORS_PER_REV;
  wire [23:0] sect6_sat = (|sect6[26:24]) ? 24'hffffff : sect6[23:0];
  wire [23:0] period_sel = ctrl_r[`CTRL_SECTOR] ? sect6_sat : rev_period_r;
  wire [24:0] rem_sh = {rem_r[23:0], dvd_r[23]};
  wire        rem_ge = rem_sh >= {1'b0, dvs_r};
  wire [24:0] kp_f = gain_fmt(kp_r);
  wire [24:0] ki_f = gain_fmt(ki_r);
  wire [23:0] err = sat24($signed({{26{speed_req_r[23]}}, speed_req_r})
                          - $signed({{26{omega_r[23]}}, omega_r}));
  wire signed [47:0] p_prod = $signed(kp_f[23:0]) * $signed(err);
  wire signed [47:0] i_prod = $signed(ki_f[23:0]) * $signed(err);
  wire signed [49:0] p_term = $signed({{2{p_prod[47]}}, p_prod}) >>> (kp_f[24] ? `SHIFT_9_15 : `SHIFT_1_23);
  wire signed [49:0] i_term = $signed({{2{i_prod[47]}}, i_prod}) >>> (ki_f[24] ? `SHIFT_9_15 : `SHIFT_1_23);
  wire [23:0] integ_nxt = sat24(i_term + $signed({{26{integ_r[23]}}, integ_r}));
  wire [23:0] out_nxt = sat24(p_term + $signed({{26{integ_nxt[23]}}, integ_nxt}));
  // ****************************************************************
  // hall synchroniser, timebase and period measurement
  // ****************************************************************
  // pins pass two flops before the edge logic looks at them
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      hall_s1_r        <= 3'h0;
      hall_s2_r        <= 3'h0;
      tb_pre_r         <= 16'h0000;
      timebase_counter <= 24'h000000;
    end
    else
    begin
      hall_s1_r <= hall_in;
      hall_s2_r <= hall_s1_r;
      // prescaled tick; the counter wraps, differences stay correct
      if (tb_pre_r >= tb_div_r)
      begin
        tb_pre_r         <= 16'h0000;
        timebase_counter <= timebase_counter + 24'h000001;
      end
      else
        tb_pre_r <= tb_pre_r + 16'h0001;
    end
  end
  // one time stamp per channel and edge polarity
  // a single process owns the stamp array, so no entry has two drivers
  genvar gi;
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      for (j = 0; j < 6; j = j + 1)
        stamp_r[j] <= 24'h000000;
    end
    else if (edge_take)
      stamp_r[edge_kind] <= timebase_counter;
  end
  // periods refresh on every accepted edge
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      last_edge_r   <= 24'h000000;
      rev_period_r  <= 24'h000000;
      sect_period_r <= 24'h000000;
    end
    else if (edge_take)
    begin
      last_edge_r   <= timebase_counter;
      sect_period_r <= timebase_counter - last_edge_r;
      rev_period_r  <= timebase_counter - stamp_r[edge_kind];
    end
  end
  // ****************************************************************
  // commutation
  // ****************************************************************
  // an edge stays pending in hall_q until the fsm is idle again
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cm_state_r         <= CM_IDLE;
      hall_q_r           <= 3'h0;
      cmd_ptr_r          <= 5'h00;
      phase_base_state_r <= {3{`ST_OFF_LOW}};
      phase_comp_state_r <= {3{`ST_OFF_LOW}};
      duty_invert_sign_r <= 3'h0;
      neg_pend_r         <= 3'h0;
    end
    else
    begin
      case (cm_state_r)
        CM_IDLE:
        begin
          // serviced at once, regardless of the pwm period
          if (edge_take)
          begin
            hall_q_r[edge_ch] <= hall_s2_r[edge_ch];
            cmd_ptr_r         <= edge_cmd;
            cm_state_r        <= CM_OFF;
          end
          else if (!ctrl_r[`CTRL_ENABLE])
            hall_q_r <= hall_s2_r;
        end
        CM_OFF, CM_ON:
        begin
          // first word of the pair, then the second
          if (cmd_ph != 2'h3)
          begin
            phase_base_state_r[cmd_ph*2 +: 2] <= cmd_base;
            phase_comp_state_r[cmd_ph*2 +: 2] <= cmd_comp;
            if (cmd_is_on)
              duty_invert_sign_r[cmd_ph] <= cmd_neg;
            else
              neg_pend_r[cmd_ph] <= cmd_neg;
          end
          cmd_ptr_r  <= cmd_ptr_r | 5'h01;
          cm_state_r <= cm_state_r[1] ? CM_ON : CM_IDLE;
        end
        default:
          cm_state_r <= CM_IDLE;
      endcase
    end
  end
  // per-phase signed duty, negated under the negative option
  wire [71:0] duty_nxt;            // next duty of all three phases
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_duty
      assign duty_nxt[gi*24 +: 24] = duty_invert_sign_r[gi] ? sat24(-$signed({{26{voltage_r[23]}}, voltage_r}))
                                                             : voltage_r;
    end
  endgenerate
  // one process registers the whole word, so the output has one driver
  always @(posedge aclk)
  begin
    if (!aresetn)
      phase_duty_r <= 72'h000000000000000000;
    else
      phase_duty_r <= duty_nxt;
  end
  // ****************************************************************
  // speed loop regulator
  // ****************************************************************
  // 24 restoring steps, then one cycle for the pi step
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rg_state_r      <= RG_IDLE;
      pwm_par_r       <= 1'b0;
      rem_r           <= 25'h0000000;
      dvd_r           <= 24'h000000;
      dvs_r           <= 24'h000000;
      quo_r           <= 24'h000000;
      div_cnt_r       <= 5'h00;
      omega_r         <= 24'h000000;
      integ_r         <= 24'h000000;
      voltage_r       <= 24'h000000;
      voltage_valid_r <= 1'b0;
    end
    else
    begin
      voltage_valid_r <= 1'b0;
      if (pwm_period_tick)
        pwm_par_r <= ~pwm_par_r;
      case (rg_state_r)
        RG_IDLE:
        begin
          // a tick landing mid-calculation is skipped, not queued
          if (pwm_period_tick && pwm_par_r && ctrl_r[`CTRL_ENABLE])
          begin
            rem_r      <= 25'h0000000;
            dvd_r      <= scale_r;
            dvs_r      <= period_sel;
            div_cnt_r  <= 5'h00;
            rg_state_r <= RG_DIV;
          end
        end
        RG_DIV:
        begin
          rem_r     <= rem_ge ? (rem_sh - {1'b0, dvs_r}) : rem_sh;
          dvd_r     <= {dvd_r[22:0], 1'b0};
          quo_r     <= {quo_r[22:0], rem_ge};
          div_cnt_r <= div_cnt_r + 5'h01;
          if (div_cnt_r == 5'h17)
          begin
            // no period yet, or a quotient past one, reads as full speed
            if ((dvs_r == 24'h000000) || quo_r[22])
              omega_r <= `FRAC_MAX;
            else
              omega_r <= {quo_r[22:0], rem_ge};
            rg_state_r <= RG_PI;
          end
        end
        RG_PI:
        begin
          integ_r         <= integ_nxt;
          voltage_r       <= out_nxt;
          voltage_valid_r <= 1'b1;
          rg_state_r      <= RG_IDLE;
        end
        default:
          rg_state_r <= RG_IDLE;
      endcase
    end
  end
  // ****************************************************************
  // axi4-lite slave
  // ****************************************************************
  wire        wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire        wr_hit = (awaddr_r[1:0] == 2'h0) && (awaddr_r <= `OFS_CMD_DATA);
  reg  [31:0] rd_mux;
  reg         rd_hit;
  // read data selection
  always @*
  begin
    rd_hit = 1'b1;
    case (s_axi_araddr)
      `OFS_CTRL:        rd_mux = {29'h0, ctrl_r};
      `OFS_SCALE:       rd_mux = {8'h00, scale_r};
      `OFS_KP:          rd_mux = kp_r;
      `OFS_KI:          rd_mux = ki_r;
      `OFS_SPEED_REQ:   rd_mux = {8'h00, speed_req_r};
      `OFS_TB_DIV:      rd_mux = {16'h0000, tb_div_r};
      `OFS_CMD_INDEX:   rd_mux = {27'h0, cmd_index_r};
      `OFS_CMD_DATA:    rd_mux = cmd_tab_r[cmd_index_r];
      `OFS_REV_PERIOD:  rd_mux = {8'h00, rev_period_r};
      `OFS_SECT_PERIOD: rd_mux = {8'h00, sect_period_r};
      `OFS_OMEGA:       rd_mux = {8'h00, omega_r};
      `OFS_VOLTAGE:     rd_mux = {8'h00, voltage_r};
      `OFS_STATUS:      rd_mux = {22'h0, ~rg_state_r[0], hall_s2_r, neg_pend_r, duty_invert_sign_r};
      default:
      begin
        rd_mux = 32'h00000000;
        rd_hit = 1'b0;
      end
    endcase
  end
  // address and data are taken independently, then written together
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `RESP_OKAY;
      s_axi_rdata   <= 32'h00000000;
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      awaddr_r      <= 8'h00;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CTRL_RST;
      scale_r       <= 24'h000000;
      kp_r          <= 32'h00000000;
      ki_r          <= 32'h00000000;
      speed_req_r   <= 24'h000000;
      tb_div_r      <= `TB_DIV_RST;
      cmd_index_r   <= 5'h00;
      for (k = 0; k < 32; k = k + 1)
        cmd_tab_r[k] <= 32'h00000000;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awaddr_r      <= s_axi_awaddr;
        aw_held_r     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wdata_r      <= s_axi_wdata;
        wstrb_r      <= s_axi_wstrb;
        w_held_r     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go)
      begin
        aw_held_r    <= 1'b0;
        w_held_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        case (awaddr_r)
          `OFS_CTRL:      ctrl_r      <= (ctrl_r & ~wmask[2:0]) | (wdata_r[2:0] & wmask[2:0]);
          `OFS_SCALE:     scale_r     <= (scale_r & ~wmask[23:0]) | (wdata_r[23:0] & wmask[23:0]);
          `OFS_KP:        kp_r        <= (kp_r & ~wmask) | (wdata_r & wmask);
          `OFS_KI:        ki_r        <= (ki_r & ~wmask) | (wdata_r & wmask);
          `OFS_SPEED_REQ: speed_req_r <= (speed_req_r & ~wmask[23:0]) | (wdata_r[23:0] & wmask[23:0]);
          `OFS_TB_DIV:    tb_div_r    <= (tb_div_r & ~wmask[15:0]) | (wdata_r[15:0] & wmask[15:0]);
          `OFS_CMD_INDEX:
          begin
            if (wstrb_r[0])
              cmd_index_r <= wdata_r[4:0];
          end
          `OFS_CMD_DATA:
          begin
            // pointer steps on so a table loads by repeated writes
            cmd_tab_r[cmd_index_r] <= (cmd_tab_r[cmd_index_r] & ~wmask) | (wdata_r & wmask);
            cmd_index_r            <= cmd_index_r + 5'h01;
          end
          default:
            cmd_index_r <= cmd_index_r;
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      // read answers one cycle after the address is taken
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rd_mux;
        s_axi_rresp   <= (rd_hit && (s_axi_araddr[1:0] == 2'h0)) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_rvalid && s_axi_rready)
      begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end
endmodule

// [testbench/bldc_hall_drive_chk.sv]
// port checker of the hall drive, bound to its top module
module bldc_hall_drive_chk
(
  // clock and reset
  input wire        aclk,
  input wire        aresetn,
  // register bus handshakes
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire        s_axi_bvalid,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  // drive side
  input wire [2:0]  hall_in,
  input wire        pwm_period_tick,
  input wire [5:0]  phase_base_state_r,
  input wire [2:0]  duty_invert_sign_r,
  input wire [71:0] phase_duty_r,
  input wire [23:0] voltage_r,
  input wire        voltage_valid_r
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] quiet_r; // clocks since the hall pins last moved, saturating
  always @(posedge aclk)
    quiet_r <= (!aresetn || hall_in != $past(hall_in)) ? 4'h0 : quiet_r + {3'h0, quiet_r != 4'hf};
  // negation saturates, since minus one has no positive twin
  function automatic [23:0] duty_of(input [23:0] v, input neg);
    duty_of = !neg ? v : (v == 24'h800000) ? 24'h7fffff : -v;
  endfunction
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
  sequence s_rd_taken; s_axi_arvalid && s_axi_arready; endsequence
  property p_wr_resp; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("late write response");
  property p_rd_resp; s_rd_taken |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("late read data");
  property p_wr_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write taken while answering");
  property p_rd_busy; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("read taken while answering");
  property p_reset_off; $rose(aresetn) |-> phase_base_state_r == 6'h2a; endproperty
  a_reset_off: assert property (p_reset_off) else $error("phases not off low after reset");
  property p_comm_cause; $changed(phase_base_state_r) |-> quiet_r < 4'hc; endproperty
  a_comm_cause: assert property (p_comm_cause) else $error("commutation without hall edge");
  property p_duty; phase_duty_r[23:0] == duty_of($past(voltage_r), $past(duty_invert_sign_r[0])); endproperty
  a_duty: assert property (p_duty) else $error("phase duty sign wrong");
  property p_volt_tick; voltage_valid_r |-> $past(pwm_period_tick, 26) || $past(pwm_period_tick, 27); endproperty
  a_volt_tick: assert property (p_volt_tick) else $error("regulation not tied to a tick");
  property p_volt_hold; $changed(voltage_r) |-> voltage_valid_r; endproperty
  a_volt_hold: assert property (p_volt_hold) else $error("voltage moved without valid");
endmodule
bind bldc_hall_drive bldc_hall_drive_chk chk (.*);

// [testbench/hall_stage_model.sv]
// hall sensor and power stage model: steps the sensors, ticks the pwm period
module hall_stage_model
#(
  parameter int GAP     = 40, // clocks per sector
  parameter int PWM_DIV = 64  // clocks per pwm period
)
(
  // clock and motion control
  input  wire       aclk,
  input  wire       run,
  input  wire       fwd,
  // sensor pins and period marker
  output wire [2:0] hall_in,
  output logic      pwm_period_tick = 1'b0
);
  timeunit 1ns;
  timeprecision 1ns;
  // six codes a revolution, one pin moves per step
  localparam logic [17:0] SEQ = {3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
  logic [2:0] sect_r = 3'h0;
  logic [7:0] cnt_r  = 8'h0;
  logic [7:0] pwm_r  = 8'h0;
  // a stopped rotor holds its sensor code
  always @(posedge aclk)
  begin
    pwm_r <= (pwm_r == PWM_DIV - 1) ? 8'h0 : pwm_r + 8'h1;
    pwm_period_tick <= (pwm_r == PWM_DIV - 1);
    cnt_r <= (!run || cnt_r == GAP - 1) ? 8'h0 : cnt_r + 8'h1;
    if (run && cnt_r == GAP - 1)
      sect_r <= fwd ? (sect_r == 3'h5 ? 3'h0 : sect_r + 3'h1) : (sect_r == 3'h0 ? 3'h5 : sect_r - 3'h1);
  end
  assign hall_in = SEQ[sect_r*3 +: 3];
endmodule

// [testbench/bldc_hall_drive_bench.sv]
// self-checking bench of the hall drive
`include "bldc_hall_consts.vh"
module bldc_hall_drive_bench;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 40;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, run = 0, fwd = 1, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, voltage_valid_r, pwm_period_tick;
  logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata, rd, tab [32];
  logic [2:0] hall_in, duty_invert_sign_r, act, h;
  logic [5:0] phase_base_state_r, phase_comp_state_r, base, comp;
  logic [71:0] phase_duty_r;
  logic [23:0] voltage_r, scale, req, omega;
  int miscompares = 0, compares = 0, seed, q, ph;
  bldc_hall_drive dut (.*);
  hall_stage_model #(.GAP(GAP), .PWM_DIV(64)) model (.aclk(aclk), .run(run), .fwd(fwd), .hall_in(hall_in),
    .pwm_period_tick(pwm_period_tick));
  initial forever #25 aclk = ~aclk;
  task automatic chk(input string what, input [31:0] seen, input [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // address and data offered together, each dropped once taken
  task automatic wr(input [7:0] a, input [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 0;
  endtask
  task automatic rd_reg(input [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 0;
  endtask
  // mirror of one command: switch-on takes its option at once
  task automatic apply(input [31:0] c);
    q = c[1:0];
    base[2*q +: 2] = c[9:8];
    comp[2*q +: 2] = c[17:16];
    if (!c[9]) act[q] = c[24];
  endtask
  task automatic end_sim;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    end_sim();
  end
  initial
  begin
    seed = $urandom(32'hc723);
    {base, comp, act} = {6'h2a, 6'h2a, 3'h0};
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    rd_reg(`OFS_CTRL);
    chk("ctrl reset", rd, 32'h0);
    rd_reg(8'h40);
    chk("unmapped read", {30'h0, resp}, 32'h2);
    wr(`OFS_REV_PERIOD, 32'h1);
    chk("read-only write", {30'h0, resp}, 32'h2);
    scale = 24'(6 * GAP * ($urandom % 16384)); // keeps the quotient in range
    req = 24'($urandom % 32'h400000);
    omega = 24'(scale / (6 * GAP));
    wr(`OFS_SCALE, {8'h0, scale});
    wr(`OFS_KP, 32'h00800000); // unit gain, reduced by magnitude
    wr(`OFS_KI, 32'h0);
    wr(`OFS_SPEED_REQ, {8'h0, req});
    wr(`OFS_CMD_INDEX, 32'h0);
    for (int i = 0; i < 32; i++)
    begin
      tab[i] = {7'h0, 1'($urandom), 6'h0, 2'($urandom), 6'h0, 2'($urandom), 8'($urandom % 3)};
      wr(`OFS_CMD_DATA, tab[i]);
    end
    // pass 0 revolution period, rising direction; pass 1 sector period, falling
    for (int m = 0; m < 2; m++)
    begin
      fwd <= !m;
      wr(`OFS_CTRL, {29'h0, 1'(!m), 1'(m), 1'b1});
      run <= 1;
      repeat (14)
      begin
        h = hall_in;
        while (hall_in === h) @(posedge aclk);
        ph = (h ^ hall_in) == 3'b001 ? 0 : (h ^ hall_in) == 3'b010 ? 1 : 2;
        apply(tab[{m[0], 2'(ph), hall_in[ph], 1'b0}]);
        apply(tab[{m[0], 2'(ph), hall_in[ph], 1'b1}]);
        repeat (8) @(posedge aclk);
        chk("base states", {26'h0, phase_base_state_r}, {26'h0, base});
        chk("comp states", {26'h0, phase_comp_state_r}, {26'h0, comp});
        chk("neg options", {29'h0, duty_invert_sign_r}, {29'h0, act});
      end
      run <= 0;
      repeat (300) @(posedge aclk);
      rd_reg(`OFS_REV_PERIOD);
      chk("rev period", {8'h0, rd[23:0]}, 6 * GAP);
      rd_reg(`OFS_SECT_PERIOD);
      chk("sector period", {8'h0, rd[23:0]}, GAP);
      rd_reg(`OFS_OMEGA);
      chk("speed", {8'h0, rd[23:0]}, {8'h0, omega});
      chk("voltage", {8'h0, voltage_r}, {8'h0, 24'(req - omega)});
    end
    end_sim();
  end
endmodule
